// ==== rtl/exec_alu.sv ====
// Eight-bit increment / OR datapath with zero detect
`timescale 1ns/100ps
`default_nettype none

module exec_alu
	import incr_or_pkg::*;
(
	// Operation select
	input  wire alu_op_e          op,
	// Operands
	input  wire logic [DATA_W-1:0] file_val,
	input  wire logic [DATA_W-1:0] work_val,
	input  wire logic [DATA_W-1:0] literal,
	// Result
	output logic      [DATA_W-1:0] result,
	output logic                   is_zero
);

	// ==========================================================
	// Datapath
	always_comb begin
		case (op)
			// The carry out is dropped, so 0xFF wraps to 0x00
			alu_inc: result = file_val + ONE; // [RULE2] [RULE5]
			alu_or:  result = work_val | literal; // [RULE7]
			default: result = file_val;
		endcase
		is_zero = (result == ZERO_BYTE);
	end

endmodule : exec_alu

`default_nettype wire

// ==== rtl/incr_or_exec.sv ====
// Execute unit for increment-skip, increment and OR-literal instructions
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [RULE1] Opcode 00 1111 with dest bit and 7-bit address is increment-skip-if-zero.
// [RULE2] Increments add one to file f; dest 0 writes W, dest 1 writes f.
// [RULE3] Increment-skip with zero result discards the already fetched next instruction.
// [RULE4] Increment-skip takes one cycle, or two with a no-operation when skipping.
// [RULE5] Opcode 00 1010 increments modulo 256, sets zero flag from result, never skips.
// [RULE6] Opcode 11 1000 with 8-bit literal is OR-literal, one cycle, one word.
// [RULE7] OR-literal ORs W with literal, writes W only, updates zero flag.
// [RULE8] Increment-skip leaves every status flag, zero included, unchanged.
module incr_or_exec
	import incr_or_pkg::*;
(
	// Clock, reset, enable
	input  wire logic               mclk,
	input  wire logic               rstn,
	input  wire logic               ce,
	// Fetched instruction and its file operand, same clock domain
	input  wire logic               instr_valid,
	input  wire logic [INSTR_W-1:0] instr,
	input  wire logic [DATA_W-1:0]  file_rdata,
	// Register file write port
	output logic                    file_we,
	output logic      [ADDR_W-1:0]  file_addr,
	output logic      [DATA_W-1:0]  file_wdata,
	// Core state
	output logic      [DATA_W-1:0]  work,
	output logic                    zero,
	// Per-slot outcome pulses
	output logic                    retired,
	output logic                    discarded
);

	// ==========================================================
	// Decode
	exec_state_e       state;
	exec_state_e       next_state;
	logic [5:0]        opcode;
	logic              dest;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] literal;
	logic              slot;
	logic              go;
	logic              is_inc_skip;
	logic              is_inc;
	logic              is_or_lit;
	logic              known;
	alu_op_e           alu_sel;
	logic [DATA_W-1:0] result;
	logic              res_zero;
	logic              skip_now;

	assign opcode  = instr[OP_MSB:OP_LSB];
	assign dest    = instr[DEST_BIT];
	assign addr    = instr[ADDR_MSB:0];
	assign literal = instr[LIT_MSB:0];

	// A slot is one accepted instruction word; ce low freezes everything
	assign slot = ce && instr_valid;
	assign go   = slot && (state == st_execute);

	assign is_inc_skip = (opcode == OP_INC_SKIP); // [RULE1]
	assign is_inc      = (opcode == OP_INC); // [RULE5]
	assign is_or_lit   = (opcode == OP_OR_LIT); // [RULE6]
	assign known       = is_inc_skip || is_inc || is_or_lit;

	always_comb begin
		if (is_or_lit) begin
			alu_sel = alu_or;
		end else if (is_inc_skip || is_inc) begin
			alu_sel = alu_inc;
		end else begin
			alu_sel = alu_pass;
		end
	end

	exec_alu u_alu (
		.op       (alu_sel),
		.file_val (file_rdata),
		.work_val (work),
		.literal  (literal),
		.result   (result),
		.is_zero  (res_zero)
	);

	// Only increment-skip may skip; plain increment never does
	assign skip_now = go && is_inc_skip && res_zero; // [RULE3] [RULE5]

	// ==========================================================
	// Skip sequencer
	always_comb begin
		case (state)
			st_execute: next_state = skip_now ? st_discard : st_execute; // [RULE3]
			// The discarded slot runs as a no-operation, then normal flow
			st_discard: next_state = slot ? st_execute : st_discard; // [RULE4]
			default:    next_state = st_execute;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state <= st_execute;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// ==========================================================
	// Working register
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			work <= W_RESET;
		end else if (go) begin
			if (is_or_lit) begin
				work <= result; // [RULE7]
			end else if ((is_inc_skip || is_inc) && dest == DEST_W) begin
				work <= result; // [RULE2]
			end
		end
	end

	// ==========================================================
	// File register write port
	// Address and data are held after the strobe so the file can sample late
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			file_we    <= 1'h0;
			file_addr  <= '0;
			file_wdata <= ZERO_BYTE;
		end else if (ce) begin
			file_we <= go && (is_inc_skip || is_inc) && dest == DEST_F; // [RULE2]
			if (go && (is_inc_skip || is_inc)) begin
				file_addr  <= addr;
				file_wdata <= result;
			end
		end
	end

	// ==========================================================
	// Zero flag: increment-skip does not touch it
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			zero <= Z_RESET;
		end else if (go && (is_inc || is_or_lit)) begin
			zero <= res_zero; // [RULE5] [RULE7] [RULE8]
		end
	end

	// ==========================================================
	// Slot outcome pulses
	// Opcodes outside this unit are left to other execute logic and are not retired
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			retired   <= 1'h0;
			discarded <= 1'h0;
		end else if (ce) begin
			retired   <= go && known; // [RULE4] [RULE6]
			discarded <= slot && (state == st_discard); // [RULE3]
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	sequence s_skip_taken;
		go && is_inc_skip && res_zero;
	endsequence

	// The discard waits for the next accepted slot, however long the gap
	sequence s_next_slot;
		state == st_discard && slot;
	endsequence

	a_skip_decode: assert property (go && opcode == 6'h0F && instr[7] |=> // [RULE1]
		file_we && file_addr == $past(addr))
		else $error("increment-skip with dest f did not write the file");

	a_inc_dest_w: assert property (go && is_inc && !dest |=> // [RULE2]
		!file_we && work == $past(file_rdata) + 8'h01)
		else $error("increment to W gave a wrong value");

	a_skip_discard: assert property (s_next_slot |=> // [RULE3]
		discarded && !retired)
		else $error("instruction after zero increment-skip was not discarded");

	a_skip_two_cycles: assert property (s_skip_taken |=> state == st_discard && !discarded) // [RULE4]
		else $error("skip did not arm the no-operation slot");

	a_no_skip_one: assert property (go && is_inc_skip && !res_zero |=> // [RULE4]
		state == st_execute && retired)
		else $error("non-zero increment-skip did not finish in one cycle");

	a_inc_wrap_zero: assert property (go && is_inc && file_rdata == 8'hFF |=> // [RULE5]
		zero && state == st_execute && file_wdata == 8'h00)
		else $error("increment of 0xFF did not wrap and set zero");

	a_or_single: assert property (go && is_or_lit |=> retired && !file_we) // [RULE6]
		else $error("OR-literal did not retire in one cycle");

	a_or_result: assert property (go && is_or_lit |=> // [RULE7]
		work == ($past(work) | $past(literal)) && zero == (work == 8'h00))
		else $error("OR-literal result or zero flag wrong");

	a_skip_keeps_z: assert property (go && is_inc_skip |=> $stable(zero)) // [RULE8]
		else $error("increment-skip changed the zero flag");

	a_inc_no_skip: assert property (go && is_inc |=> state == st_execute) // [RULE5]
		else $error("plain increment armed a skip");

	a_dest_f_keeps_w: assert property (go && !is_or_lit && known && dest |=> $stable(work)) // [RULE2]
		else $error("increment to the file register changed W");

	a_unknown_idle: assert property (go && !known |=> // [RULE6]
		!retired && !file_we && $stable(work) && $stable(zero))
		else $error("opcode outside this unit changed state");

endmodule : incr_or_exec

`default_nettype wire

// ==== rtl/incr_or_pkg.sv ====
// Constants and types for the increment and OR-literal execute unit
package incr_or_pkg;

	// ==========================================================
	// Instruction word fields
	localparam int          INSTR_W   = 14;
	localparam int          DATA_W    = 8;
	localparam int          ADDR_W    = 7;
	localparam int          OP_MSB    = 13;
	localparam int          OP_LSB    = 8;
	localparam int          DEST_BIT  = 7;
	localparam int          ADDR_MSB  = 6;
	localparam int          LIT_MSB   = 7;

	// ==========================================================
	// Opcodes in bits 13:8
	localparam logic [5:0]  OP_INC_SKIP = 6'h0F;
	localparam logic [5:0]  OP_INC      = 6'h0A;
	localparam logic [5:0]  OP_OR_LIT   = 6'h38;

	// ==========================================================
	// Destination encoding and reset values
	localparam logic        DEST_W      = 1'h0;
	localparam logic        DEST_F      = 1'h1;
	localparam logic [7:0]  W_RESET     = 8'h00;
	localparam logic        Z_RESET     = 1'h0;
	localparam logic [7:0]  ONE         = 8'h01;
	localparam logic [7:0]  ZERO_BYTE   = 8'h00;

	// ==========================================================
	// ALU selections and sequencer states
	typedef enum logic [1:0] {
		alu_inc  = 2'h0,
		alu_or   = 2'h1,
		alu_pass = 2'h2
	} alu_op_e;

	typedef enum logic [0:0] {
		st_execute = 1'h0,
		st_discard = 1'h1
	} exec_state_e;

endpackage : incr_or_pkg

// ==== tb/incr_or_exec_test.sv ====
// Self-checking bench for the increment and OR-literal execute unit
`timescale 1ns/100ps
`default_nettype none

module incr_or_exec_test;
	import incr_or_pkg::*;

	typedef struct {
		logic              disc;
		logic              we;
		logic [DATA_W-1:0] w;
		logic              z;
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] wd;
	} note_s;

	logic               mclk, rstn, ce, instr_valid, ce_seen;
	logic [INSTR_W-1:0] instr;
	logic [DATA_W-1:0]  file_rdata, file_wdata, work, m_w, m_wd;
	logic [ADDR_W-1:0]  file_addr, m_a;
	logic               file_we, zero, retired, discarded, m_z, m_skip;
	int                 err_count, total_checks;
	note_s              q[$];
	note_s              n;

	incr_or_exec dut_u (.mclk(mclk), .rstn(rstn), .ce(ce), .instr_valid(instr_valid),
		.instr(instr), .file_rdata(file_rdata), .file_we(file_we), .file_addr(file_addr),
		.file_wdata(file_wdata), .work(work), .zero(zero), .retired(retired),
		.discarded(discarded));

	// ==========================================================
	// Checking
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim;
		if (q.size() != 0)
			err_count++;
		$display("errors %0d checks %0d", err_count, total_checks);
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	// Held pulses while ce is low must not be counted twice
	always @(posedge mclk) ce_seen <= ce && rstn;

	always @(negedge mclk) begin
		if (ce_seen && (retired === 1'b1 || discarded === 1'b1)) begin
			if (q.size() == 0) begin
				check(8'h01, 8'h00);
			end else begin
				n = q.pop_front();
				check(discarded, n.disc);
				check(retired, !n.disc);
				check(file_we, n.we);
				check(work, n.w);
				check(zero, n.z);
				check(file_addr, n.a);
				check(file_wdata, n.wd);
			end
		end
	end

	// ==========================================================
	// Driving and reference model
	task automatic slot(input logic v, input logic c, input logic [INSTR_W-1:0] wd,
		input logic [DATA_W-1:0] fd);
		logic [DATA_W-1:0] r;
		@(posedge mclk);
		instr_valid <= v;
		ce <= c;
		instr <= wd;
		file_rdata <= fd;
		r = fd + ONE;
		if (v && c) begin
			if (m_skip) begin
				m_skip = 1'b0;
				q.push_back('{1'b1, 1'b0, m_w, m_z, m_a, m_wd});
			end else if (wd[13:8] == OP_OR_LIT) begin
				m_w = m_w | wd[7:0];
				m_z = (m_w == ZERO_BYTE);
				q.push_back('{1'b0, 1'b0, m_w, m_z, m_a, m_wd});
			end else if (wd[13:8] == OP_INC || wd[13:8] == OP_INC_SKIP) begin
				m_a = wd[6:0];
				m_wd = r;
				if (wd[7] == DEST_W)
					m_w = r;
				if (wd[13:8] == OP_INC)
					m_z = (r == ZERO_BYTE);
				else
					m_skip = (r == ZERO_BYTE);
				q.push_back('{1'b0, wd[7], m_w, m_z, m_a, m_wd});
			end
		end
	endtask : slot

	task automatic do_reset(input int cycles);
		@(posedge mclk);
		rstn <= 1'b0;
		m_w = W_RESET;
		m_z = Z_RESET;
		m_a = '0;
		m_wd = '0;
		m_skip = 1'b0;
		repeat (cycles) @(posedge mclk);
		rstn <= 1'b1;
	endtask : do_reset

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	initial begin
		#(2000 * 100);
		err_count++;
		end_sim;
	end

	// ==========================================================
	// Scenarios
	initial begin
		rstn = 1'b0;
		ce = 1'b0;
		instr_valid = 1'b0;
		instr = '0;
		file_rdata = '0;
		err_count = 0;
		total_checks = 0;
		void'($urandom(36121));
		do_reset(4);
		@(negedge mclk);
		check(work, W_RESET);
		check(zero, Z_RESET);
		check(file_we, 1'b0);
		slot(1, 1, {OP_OR_LIT, 8'h00}, 8'h3C);
		slot(1, 1, {OP_OR_LIT, 8'h9A}, 8'h00);
		slot(1, 1, {OP_OR_LIT, 8'h35}, 8'h00);
		slot(1, 1, {OP_INC, DEST_F, 7'h10}, 8'hFF);
		slot(1, 1, {OP_OR_LIT, 8'h40}, 8'h00);
		// Skip back to back, then a non-skipping one
		slot(1, 1, {OP_INC_SKIP, DEST_W, 7'h7F}, 8'hFF);
		slot(1, 1, {OP_OR_LIT, 8'hFF}, 8'h00);
		slot(1, 1, {OP_INC_SKIP, DEST_F, 7'h00}, 8'h41);
		slot(1, 1, {OP_INC, DEST_W, 7'h05}, 8'h05);
		// Skip waits across gaps and a frozen cycle
		slot(1, 1, {OP_INC_SKIP, DEST_F, 7'h22}, 8'hFF);
		slot(0, 1, 14'h0000, 8'h00);
		slot(1, 0, {OP_INC, DEST_W, 7'h01}, 8'h00);
		slot(1, 1, {OP_INC, DEST_W, 7'h01}, 8'h00);
		slot(1, 1, 14'h0B10, 8'h00);
		// Reset cancels a pending skip
		slot(1, 1, {OP_INC_SKIP, DEST_F, 7'h33}, 8'hFF);
		slot(0, 1, 14'h0000, 8'h00);
		do_reset(2);
		slot(1, 1, {OP_INC, DEST_W, 7'h01}, 8'h7F);
		repeat (400)
			slot($urandom % 8 != 0, $urandom % 8 != 0,
				{6'($urandom % 3 == 0 ? OP_INC_SKIP : $urandom % 2 ? OP_OR_LIT :
				$urandom % 2 ? OP_INC : 6'($urandom)), 8'($urandom)},
				$urandom % 3 == 0 ? 8'hFF : 8'($urandom));
		slot(0, 1, 14'h0000, 8'h00);
		slot(0, 1, 14'h0000, 8'h00);
		end_sim;
	end

endmodule : incr_or_exec_test

`default_nettype wire
